/* File: sim/spau_mem_model.sv */
`timescale 1ns/100ps
module spau_mem_model (
   input  wire logic           mclk,
   input  wire logic           reset,
   input  spau_pkg::spau_mem_s mem,
   input  wire logic [3:0]     delay,
   output logic                mem_ack,
   output logic [31:0]         mem_rdata,
   output logic [31:0]         last_addr,
   output logic [31:0]         last_wdata
);
   // ==========================================
   // word store keyed on the low address byte, enough for a short bench
   logic [31:0]  store [0:255];
   logic [255:0] known_q;
   logic [3:0]   wait_q;

   // ==========================================
   // answer after a set wait; read data only valid beside ack
   always @(posedge mclk) begin
      if (reset || !mem.req || mem_ack) begin
         wait_q    <= 4'h0;
         mem_ack   <= 1'b0;
         if (reset) begin
            known_q <= '0;
         end
         // toggles so a late sample never matches by luck
         mem_rdata <= reset ? 32'h5555_AAAA : ~mem_rdata;
      end else if (wait_q != delay) begin
         wait_q    <= wait_q + 4'h1;
         mem_rdata <= ~mem_rdata;
      end else begin
         mem_ack   <= 1'b1;
         last_addr <= mem.addr;
         if (mem.we) begin
            store[mem.addr[7:0]]   <= mem.wdata;
            known_q[mem.addr[7:0]] <= 1'b1;
            last_wdata             <= mem.wdata;
         end
         mem_rdata <= known_q[mem.addr[7:0]] ? store[mem.addr[7:0]] : ~mem.addr;
      end
   end
endmodule : spau_mem_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
`include "spau_regs.svh"
module tb;
   logic                   mclk;
   logic                   reset;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [31:0]            reg_rdata;
   logic                   cmd_valid;
   logic                   cmd_ready;
   spau_pkg::spau_cmd_s    cmd;
   logic                   cmd_done;
   logic [31:0]            instruction_pointer;
   logic [31:0]            explicit_addr;
   logic                   explicit_wide;
   spau_pkg::spau_mem_s    mem;
   logic                   mem_ack;
   logic [31:0]            mem_rdata;
   logic [3:0]             delay;
   logic [31:0]            last_addr;
   logic [31:0]            last_wdata;
   int                     miscompares;
   int                     compares;
   localparam logic [31:0] BASE = 32'h0001_0000;

   spau_top u_spau_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .cmd_done(cmd_done), .instruction_pointer(instruction_pointer),
      .explicit_addr(explicit_addr), .explicit_wide(explicit_wide), .mem(mem), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   spau_mem_model u_spau_mem_model (.mclk(mclk), .reset(reset), .mem(mem), .delay(delay),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .last_addr(last_addr), .last_wdata(last_wdata));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ==========================================
   // report and compare
   task end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // ==========================================
   // register bus, entered just after a rising edge
   task reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      // one idle edge so a following write never reassigns the strobe in this step
      @(posedge mclk);
   endtask : reg_write

   task reg_check(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      @(negedge mclk);
      chk(reg_rdata, exp, "register read");
      @(posedge mclk);
   endtask : reg_check

   // ==========================================
   // one command; selector and operand address reuse the data word
   task run(input spau_pkg::spau_op_e op, input logic v16, input logic cd, input logic ovr,
            input logic [15:0] rel, input logic [31:0] d);
      int n;
      cmd       <= '{op, v16, cd, ovr, rel, d[15:0], d, d};
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      @(negedge mclk);
      // only commands without a memory step stay ready after the take
      chk(32'(cmd_ready), 32'(op == spau_pkg::OP_NONE || op == spau_pkg::OP_LOAD_FAR),
          "ready after take");
      n = 1;
      while (cmd_done !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      if (cmd_done !== 1'b1) begin
         miscompares++;
         $display("BAD %0t command never completed", $time);
         end_of_test;
      end else @(posedge mclk);
   endtask : run

   initial begin
      reset       = 1'b1;
      reg_addr    = 8'h00;
      reg_wdata   = 32'h0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      cmd_valid   = 1'b0;
      cmd         = '0;
      delay       = 4'h2;
      miscompares = 0;
      compares    = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      // reset values, 0x18 unmapped
      for (int i = 0; i < 7; i++) reg_check(8'(i * 4), 32'h0);
      $display("test reset done");

      // wide stack, slow memory; borrow crosses bit 16
      reg_write(`SPAU_OFF_SS_BASE, BASE);
      reg_write(`SPAU_OFF_CTRL, 32'h1);
      reg_write(`SPAU_OFF_SP_WIDE, 32'h0002_0000);
      run(spau_pkg::OP_PUSH, 1'b0, 1'b1, 1'b0, 16'h0, 32'hCAFE_0001);
      chk(last_addr, BASE + 32'h0001_FFFC, "push address");
      chk(last_wdata, 32'hCAFE_0001, "push data");
      reg_check(`SPAU_OFF_SP_WIDE, 32'h0001_FFFC);
      run(spau_pkg::OP_PUSH, 1'b1, 1'b1, 1'b0, 16'h0, 32'h0000_BEEF);
      reg_check(`SPAU_OFF_SP_WIDE, 32'h0001_FFFA);
      reg_check(`SPAU_OFF_STATUS, 32'h2);
      run(spau_pkg::OP_PUSH_SEL, 1'b0, 1'b1, 1'b0, 16'h0, 32'h0000_0023);
      chk(last_addr, BASE + 32'h0001_FFF8, "selector address");
      reg_check(`SPAU_OFF_SP_WIDE, 32'h0001_FFF8);
      run(spau_pkg::OP_CALL, 1'b0, 1'b1, 1'b0, 16'h0, 32'h1234_5678);
      chk(last_addr, BASE + 32'h0001_FFF4, "call address");
      delay <= 4'h0;
      run(spau_pkg::OP_RETURN, 1'b0, 1'b1, 1'b0, 16'h0008, 32'h0);
      chk(last_addr, BASE + 32'h0001_FFF4, "return address");
      chk(instruction_pointer, 32'h1234_5678, "return pointer");
      reg_check(`SPAU_OFF_SP_WIDE, 32'h0002_0000);
      $display("test wide done");

      // narrow stack: step follows code flag, 16-bit wrap
      reg_write(`SPAU_OFF_CTRL, 32'h0);
      reg_write(`SPAU_OFF_SP_WIDE, 32'hABCD_0002);
      run(spau_pkg::OP_PUSH, 1'b0, 1'b1, 1'b0, 16'h0, 32'h5A5A_A5A5);
      chk(last_addr, BASE + 32'h0000_FFFE, "narrow address");
      reg_check(`SPAU_OFF_SP_WIDE, 32'hABCD_FFFE);
      delay <= 4'h1;
      run(spau_pkg::OP_PUSH, 1'b0, 1'b0, 1'b0, 16'h0, 32'h0000_1357);
      reg_check(`SPAU_OFF_SP_WIDE, 32'hABCD_FFFC);
      run(spau_pkg::OP_POP, 1'b0, 1'b0, 1'b0, 16'h0, 32'h0);
      reg_check(`SPAU_OFF_POP_DATA, 32'h0000_1357);
      reg_check(`SPAU_OFF_SP_WIDE, 32'hABCD_FFFE);
      run(spau_pkg::OP_POP, 1'b0, 1'b1, 1'b0, 16'h0, 32'h0);
      reg_check(`SPAU_OFF_POP_DATA, 32'h5A5A_A5A5);
      reg_check(`SPAU_OFF_SP_WIDE, 32'hABCD_0002);
      $display("test narrow done");

      // selector and pointer in one far load
      run(spau_pkg::OP_LOAD_FAR, 1'b0, 1'b1, 1'b0, 16'h0, 32'h0000_2000);
      reg_check(`SPAU_OFF_SS_SEL, 32'h0000_2000);
      reg_check(`SPAU_OFF_SP_WIDE, 32'h0000_2000);
      $display("test far load done");

      // operand address size: code flag against prefix, all four
      for (int i = 0; i < 4; i++) begin
         run(spau_pkg::OP_NONE, 1'b0, i[1], i[0], 16'h0, 32'h1234_5678);
         chk(32'(explicit_wide), 32'(i[1] ^ i[0]), "operand size");
         chk(explicit_addr, (i[1] ^ i[0]) ? 32'h1234_5678 : 32'h0000_5678, "operand address");
      end
      $display("test operand size done");
      end_of_test;
   end
endmodule : tb

/* File: src/spau_pkg.sv */
package spau_pkg;

   // ==========================================
   // stack operations from instruction decode
   typedef enum logic [2:0] {
      OP_NONE,
      OP_PUSH,
      OP_PUSH_SEL,
      OP_POP,
      OP_CALL,
      OP_RETURN,
      OP_LOAD_FAR
   } spau_op_e;

   typedef struct packed {
      spau_op_e    op;
      logic        val16;
      logic        code_d;
      logic        addr_ovr;
      logic [15:0] rel_bytes;
      logic [15:0] sel;
      logic [31:0] data;
      logic [31:0] ea;
   } spau_cmd_s;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } spau_mem_s;

endpackage : spau_pkg

/* File: src/spau_regs.svh */
`ifndef SPAU_REGS_SVH
`define SPAU_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define SPAU_ADDR_W        8
`define SPAU_OFF_SP_WIDE   8'h00
`define SPAU_OFF_SS_SEL    8'h04
`define SPAU_OFF_SS_BASE   8'h08
`define SPAU_OFF_CTRL      8'h0C
`define SPAU_OFF_STATUS    8'h10
`define SPAU_OFF_POP_DATA  8'h14

// ==========================================
// field positions and reset values
`define SPAU_CTRL_BIG_BIT  0
`define SPAU_STAT_BUSY_BIT 0
`define SPAU_STAT_ALGN_BIT 1
`define SPAU_RST_SP        32'h0000_0000
`define SPAU_RST_SEL       16'h0000
`define SPAU_RST_BASE      32'h0000_0000
`define SPAU_RST_BIG       1'b0

// ==========================================
// step sizes in bytes and the dword alignment mask
`define SPAU_STEP_NARROW   32'h0000_0002
`define SPAU_STEP_WIDE     32'h0000_0004
`define SPAU_DW_MASK       32'hFFFF_FFFC

`endif

/* File: src/spau_top.sv */
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "spau_regs.svh"

module spau_top (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic [`SPAU_ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [31:0]               reg_rdata,
   input  wire logic                      cmd_valid,
   output logic                           cmd_ready,
   input  spau_pkg::spau_cmd_s            cmd,
   output logic                           cmd_done,
   output logic      [31:0]               instruction_pointer,
   output logic      [31:0]               explicit_addr,
   output logic                           explicit_wide,
   output spau_pkg::spau_mem_s            mem,
   input  wire logic                      mem_ack,
   input  wire logic [31:0]               mem_rdata
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADJ,
      S_WR,
      S_RD,
      S_POST,
      S_REL
   } spau_state_e;

   spau_state_e          state_q;
   spau_pkg::spau_cmd_s  cmd_q;
   logic [31:0]          sp_q;
   logic [31:0]          sp_d;
   logic [15:0]          ss_sel_q;
   logic [31:0]          ss_base_q;
   logic                 ss_big_q;
   logic [31:0]          pop_data_q;
   logic                 done_q;
   logic                 accept;
   logic [31:0]          step;
   logic [31:0]          push_sp;

   // ==========================================
   // address and pointer helpers
   function automatic logic [31:0] tos_off(input logic [31:0] sp, input logic big);
      tos_off = big ? sp : {16'h0000, sp[15:0]};
   endfunction : tos_off

   function automatic logic [31:0] wrap(input logic [31:0] old, input logic [31:0] res,
                                        input logic big);
      wrap = big ? res : {old[31:16], res[15:0]};
   endfunction : wrap

   // segment base plus offset; no limit test, segments may span 4 GB
   function automatic logic [31:0] lin(input logic [31:0] base, input logic [31:0] off);
      lin = base + off;
   endfunction : lin

   assign accept    = cmd_valid && (state_q == S_IDLE);
   assign cmd_ready = (state_q == S_IDLE);
   assign cmd_done  = done_q;

   // ==========================================
   // step size and pre-decremented pointer
   always_comb begin
      if (cmd_q.code_d && !cmd_q.val16) begin
         step = `SPAU_STEP_WIDE;
      end else begin
         step = `SPAU_STEP_NARROW;
      end
   end

   always_comb begin
      push_sp = sp_q - step;
      if (cmd_q.op == spau_pkg::OP_PUSH_SEL && cmd_q.code_d) begin
         // selector is two bytes, pointer snaps down to the next dword slot
         push_sp = (sp_q - `SPAU_STEP_NARROW) & `SPAU_DW_MASK;
      end
   end

   // misalignment is only reported, never faulted
   always_comb begin
      sp_d = sp_q;
      case (state_q)
         S_ADJ:   sp_d = wrap(sp_q, push_sp, ss_big_q);
         S_POST:  sp_d = wrap(sp_q, sp_q + step, ss_big_q);
         S_REL:   sp_d = wrap(sp_q, sp_q + {16'h0000, cmd_q.rel_bytes}, ss_big_q);
         default: sp_d = sp_q;
      endcase
   end

   // ==========================================
   // sequencer
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= S_IDLE;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (accept) begin
                  case (cmd.op)
                     spau_pkg::OP_PUSH,
                     spau_pkg::OP_PUSH_SEL,
                     spau_pkg::OP_CALL: state_q <= S_ADJ;
                     spau_pkg::OP_POP,
                     spau_pkg::OP_RETURN: state_q <= S_RD;
                     default:           state_q <= S_IDLE;
                  endcase
               end
            end
            S_ADJ: state_q <= S_WR;
            S_WR: begin
               if (mem_ack) begin
                  state_q <= S_IDLE;
               end
            end
            S_RD: begin
               if (mem_ack) begin
                  state_q <= S_POST;
               end
            end
            S_POST: state_q <= (cmd_q.op == spau_pkg::OP_RETURN) ? S_REL : S_IDLE;
            S_REL:  state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == S_WR && mem_ack)
                || (state_q == S_POST && cmd_q.op != spau_pkg::OP_RETURN)
                || (state_q == S_REL)
                || (accept && (cmd.op == spau_pkg::OP_LOAD_FAR || cmd.op == spau_pkg::OP_NONE));
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cmd_q <= '0;
      end else if (accept) begin
         cmd_q <= cmd;
      end
   end

   // ==========================================
   // explicit operand address, its own size attribute
   always_ff @(posedge mclk) begin
      if (reset) begin
         explicit_addr <= 32'h0000_0000;
         explicit_wide <= 1'b0;
      end else if (accept) begin
         explicit_wide <= cmd.code_d ^ cmd.addr_ovr;
         explicit_addr <= (cmd.code_d ^ cmd.addr_ovr) ? cmd.ea : {16'h0000, cmd.ea[15:0]};
      end
   end

   // ==========================================
   // stack pointer and segment state
   always_ff @(posedge mclk) begin
      if (reset) begin
         sp_q <= `SPAU_RST_SP;
      end else if (accept && cmd.op == spau_pkg::OP_LOAD_FAR) begin
         sp_q <= cmd.data;
      end else if (state_q == S_IDLE && reg_wr && reg_addr == `SPAU_OFF_SP_WIDE) begin
         sp_q <= reg_wdata;
      end else begin
         sp_q <= sp_d;
      end
   end

   // far load takes selector and pointer in one step
   always_ff @(posedge mclk) begin
      if (reset) begin
         ss_sel_q  <= `SPAU_RST_SEL;
         ss_base_q <= `SPAU_RST_BASE;
         ss_big_q  <= `SPAU_RST_BIG;
      end else if (accept && cmd.op == spau_pkg::OP_LOAD_FAR) begin
         ss_sel_q <= cmd.sel;
      end else if (state_q == S_IDLE && reg_wr) begin
         // segment changes only between operations to keep addresses coherent
         if (reg_addr == `SPAU_OFF_SS_SEL) begin
            ss_sel_q <= reg_wdata[15:0];
         end
         if (reg_addr == `SPAU_OFF_SS_BASE) begin
            ss_base_q <= reg_wdata;
         end
         if (reg_addr == `SPAU_OFF_CTRL) begin
            ss_big_q <= reg_wdata[`SPAU_CTRL_BIG_BIT];
         end
      end
   end

   // ==========================================
   // memory port
   always_ff @(posedge mclk) begin
      if (reset) begin
         mem <= '0;
      end else if (state_q == S_ADJ) begin
         mem.req   <= 1'b1;
         mem.we    <= 1'b1;
         mem.addr  <= lin(ss_base_q, tos_off(sp_d, ss_big_q));
         mem.wdata <= cmd_q.data;
      end else if (accept && (cmd.op == spau_pkg::OP_POP || cmd.op == spau_pkg::OP_RETURN)) begin
         mem.req  <= 1'b1;
         mem.we   <= 1'b0;
         mem.addr <= lin(ss_base_q, tos_off(sp_q, ss_big_q));
      end else if (mem_ack) begin
         mem.req <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         pop_data_q <= 32'h0000_0000;
      end else if (state_q == S_RD && mem_ack) begin
         pop_data_q <= mem_rdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         instruction_pointer <= 32'h0000_0000;
      end else if (state_q == S_RD && mem_ack && cmd_q.op == spau_pkg::OP_RETURN) begin
         instruction_pointer <= mem_rdata;
      end
   end

   // ==========================================
   // register read port
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SPAU_OFF_SP_WIDE:  reg_rdata <= sp_q;
            `SPAU_OFF_SS_SEL:   reg_rdata <= {16'h0000, ss_sel_q};
            `SPAU_OFF_SS_BASE:  reg_rdata <= ss_base_q;
            `SPAU_OFF_CTRL:     reg_rdata <= {31'h0000_0000, ss_big_q};
            `SPAU_OFF_STATUS:   reg_rdata <= {30'h0000_0000,
                                              (ss_big_q ? (sp_q[1:0] != 2'b00) : sp_q[0]),
                                              (state_q != S_IDLE)};
            `SPAU_OFF_POP_DATA: reg_rdata <= pop_data_q;
            default:            reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ==========================================
   // checks
   a_push_writes_new: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_ADJ) |=> (mem.req && mem.we && mem.addr == ss_base_q + tos_off(sp_q, ss_big_q)))
      else $error("push write not at lowered pointer");

   a_pop_reads_first: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_RD && mem_ack) |=> (state_q == S_POST && sp_q == $past(sp_q)) ##1 (sp_q != $past(sp_q)))
      else $error("pop raised pointer before read");

   a_addr_in_seg: assert property (@(posedge mclk) disable iff (reset)
      (mem.req && (state_q == S_WR || state_q == S_RD)) |-> mem.addr == ss_base_q + tos_off(sp_q, ss_big_q))
      else $error("stack address not in stack segment");

   a_wide_step: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_ADJ && ss_big_q && cmd_q.code_d && !cmd_q.val16 && cmd_q.op == spau_pkg::OP_PUSH)
      |=> sp_q == $past(sp_q) - 32'h0000_0004)
      else $error("wide push step wrong");

   a_val16_step: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_ADJ && ss_big_q && cmd_q.code_d && cmd_q.val16 && cmd_q.op == spau_pkg::OP_PUSH)
      |=> sp_q == $past(sp_q) - 32'h0000_0002)
      else $error("16-bit push on wide stack corrected");

   a_sel_aligned: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_ADJ && cmd_q.code_d && cmd_q.op == spau_pkg::OP_PUSH_SEL) |=> sp_q[1:0] == 2'b00)
      else $error("selector push left pointer unaligned");

   a_narrow_upper: assert property (@(posedge mclk) disable iff (reset)
      (!ss_big_q && state_q != S_IDLE) |=> sp_q[31:16] == $past(sp_q[31:16]))
      else $error("narrow stack touched upper pointer half");

   a_ea_size: assert property (@(posedge mclk) disable iff (reset)
      (accept && !(cmd.code_d ^ cmd.addr_ovr)) |=> (!explicit_wide && explicit_addr[31:16] == 16'h0000))
      else $error("explicit operand size wrong");

   a_ret_release: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_REL && ss_big_q) |=> (sp_q == $past(sp_q) + {16'h0000, $past(cmd_q.rel_bytes)} && cmd_done))
      else $error("return did not release bytes");

   a_pop_narrow_step: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_POST && !cmd_q.code_d) |=> sp_q[15:0] == $past(sp_q[15:0]) + 16'h0002)
      else $error("pop step ignores code size flag");

   a_pop_wide_step: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_POST && cmd_q.code_d && !cmd_q.val16) |=> sp_q[15:0] == $past(sp_q[15:0]) + 16'h0004)
      else $error("wide pop step wrong");

   a_narrow_range: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_WR && mem.req && !ss_big_q) |-> (mem.addr - ss_base_q) <= 32'h0000_FFFF)
      else $error("narrow stack offset above 16 bits");

   a_wide_offset: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_WR && mem.req && ss_big_q) |-> mem.addr == ss_base_q + sp_q)
      else $error("wide stack offset not full pointer");

   a_push_item: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_ADJ) |=> mem.wdata == $past(cmd_q.data))
      else $error("push wrote wrong item");

   a_pop_is_read: assert property (@(posedge mclk) disable iff (reset)
      (accept && cmd.op == spau_pkg::OP_POP) |=> (mem.req && !mem.we))
      else $error("pop did not start with a read");

   a_ret_pointer: assert property (@(posedge mclk) disable iff (reset)
      (state_q == S_RD && mem_ack && cmd_q.op == spau_pkg::OP_RETURN) |=> instruction_pointer == $past(mem_rdata))
      else $error("return pointer not taken from stack");

   a_explicit_wide: assert property (@(posedge mclk) disable iff (reset)
      (accept && (cmd.code_d ^ cmd.addr_ovr)) |=> (explicit_wide && explicit_addr == $past(cmd.ea)))
      else $error("wide operand address cut");

endmodule : spau_top
